/* File: pcb_pkg.sv */
// Package with constants and types for the pulse counter block
package pcb_pkg;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CNT2_VALUE  = 8'h00;
	localparam logic [7:0] OFS_CNT2_SETP   = 8'h04;
	localparam logic [7:0] OFS_CNT2_LIMIT  = 8'h08;
	localparam logic [7:0] OFS_CNT1_CTRL   = 8'h0C;
	localparam logic [7:0] OFS_CNT2_CTRL   = 8'h10;
	localparam logic [7:0] OFS_BRK_SRC     = 8'h14;
	localparam logic [7:0] OFS_BRK_FREQ    = 8'h18;
	localparam logic [7:0] OFS_BRK_TIME    = 8'h1C;
	localparam logic [7:0] OFS_CNT1_VALUE  = 8'h20;
	localparam logic [7:0] OFS_CNT1_RAW    = 8'h24;
	localparam logic [7:0] OFS_CNT1_SETP   = 8'h28;
	localparam logic [7:0] OFS_CNT1_LIMIT  = 8'h2C;
	localparam logic [7:0] OFS_GEAR_NUM    = 8'h30;
	localparam logic [7:0] OFS_GEAR_DEN    = 8'h34;
	localparam logic [7:0] OFS_STATUS      = 8'h38;

	// ------------------------------------------------------------------
	// Status bit positions
	// ------------------------------------------------------------------
	localparam int STS_BRK_FAULT = 0;
	localparam int STS_CNT1_HIT  = 1;
	localparam int STS_CNT2_HIT  = 2;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] RST_CNT2_SETP  = 16'h03E8;
	localparam logic [15:0] RST_CNT2_LIMIT = 16'hFFFF;
	localparam logic [15:0] RST_CNT1_CTRL  = 16'h0001;
	localparam logic [15:0] RST_CNT2_CTRL  = 16'h0064;
	localparam logic [15:0] RST_BRK_SRC    = 16'h0001;
	localparam logic [15:0] RST_BRK_FREQ   = 16'h03E8;
	localparam logic [15:0] RST_BRK_TIME   = 16'h0000;
	localparam logic [31:0] RST_CNT1_SETP  = 32'h0000_03E8;
	localparam logic [31:0] RST_CNT1_LIMIT = 32'hFFFF_FFFF;
	localparam logic [15:0] RST_GEAR_NUM   = 16'h0001;
	localparam logic [15:0] RST_GEAR_DEN   = 16'h0001;

	// ------------------------------------------------------------------
	// Timing: detection time counts in milliseconds
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_PERIOD_NS  = 1000000;
	localparam int MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		PCB_RUN,
		PCB_COAST,
		PCB_RAMP,
		PCB_ESTOP
	} pcb_stop_t;

	typedef struct packed {
		logic      wrap;
		pcb_stop_t stop_act;
		logic      retain;
	} pcb_ctrl_t;

	// Decimal digits of a control word
	function automatic pcb_ctrl_t pcb_decode(input logic [15:0] w);
		pcb_ctrl_t c;
		logic [15:0] u;
		logic [15:0] t;
		logic [15:0] h;
		u = w % 16'd10;
		t = (w / 16'd10) % 16'd10;
		h = (w / 16'd100) % 16'd10;
		c.wrap     = (u == 16'd1);
		c.stop_act = (t > 16'd3) ? PCB_RUN : pcb_stop_t'(t[1:0]);
		c.retain   = (h == 16'd1);
		return c;
	endfunction

endpackage

/* File: pcb_sync.sv */
// Two-stage synchroniser with rising-edge pulse per input pin
`timescale 1ns/1ps
`default_nettype none
module pcb_sync #(
	parameter int N = 5
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [N-1:0] pin_in,
	output logic      [N-1:0] level,
	output logic      [N-1:0] rise
);
	logic [N-1:0] meta_r;
	logic [N-1:0] sync_r;
	logic [N-1:0] last_r;

	// ------------------------------------------------------------------
	// Per-pin stages
	// ------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_pin
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					meta_r[i] <= 1'b0;
					sync_r[i] <= 1'b0;
					last_r[i] <= 1'b0;
				end else begin
					meta_r[i] <= pin_in[i];
					sync_r[i] <= meta_r[i];
					last_r[i] <= sync_r[i];
				end
			end
			assign level[i] = sync_r[i];
			assign rise[i]  = sync_r[i] & ~last_r[i];
		end
	endgenerate
endmodule
`default_nettype wire

/* File: pcb_count.sv */
// Pulse counter with limit, set-value flag, clear and power-down loss
`timescale 1ns/1ps
`default_nettype none
module pcb_count #(
	parameter int W = 16
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             inc,
	input  wire logic             clr,
	input  wire logic             pwr_down,
	input  wire pcb_pkg::pcb_ctrl_t ctrl,
	input  wire logic [W-1:0]     limit,
	input  wire logic [W-1:0]     setp,
	output logic      [W-1:0]     count,
	output logic                  reached
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         hit_r;
	logic         hit_nxt;

	// ------------------------------------------------------------------
	// Next count
	// ------------------------------------------------------------------
	always_comb begin
		cnt_nxt = cnt_r;
		if (clr) begin
			cnt_nxt = '0;
		end else if (pwr_down && !ctrl.retain) begin
			cnt_nxt = '0;
		end else if (inc) begin
			if (cnt_r >= limit) begin
				cnt_nxt = ctrl.wrap ? '0 : cnt_r;
			end else begin
				cnt_nxt = cnt_r + 1'b1;
			end
		end
		hit_nxt = (cnt_nxt >= setp);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
			hit_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			hit_r <= hit_nxt;
		end
	end

	assign count   = cnt_r;
	assign reached = hit_r;
endmodule
`default_nettype wire

/* File: pcb_top.sv */
// Two pulse counters with material-break detection and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module pcb_top #(
	parameter int MS_CYCLES = pcb_pkg::MS_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        cnt1_pulse_in,
	input  wire logic        cnt1_clr_in,
	input  wire logic        cnt2_pulse_in,
	input  wire logic        cnt2_clr_in,
	input  wire logic        pwr_down_in,
	input  wire logic [15:0] run_freq,
	output logic             cnt1_reached_out,
	output logic             cnt2_reached_out,
	output logic [1:0]       stop_cmd,
	output logic             brk_fault_out
);
	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic        awready_r, awready_nxt, wready_r, wready_nxt;
	logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt;
	logic        rvalid_r, rvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic [7:0]  aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic [3:0]  w_strb_r, w_strb_nxt;

	logic [15:0] cnt2_setp_r, cnt2_setp_nxt, cnt2_limit_r, cnt2_limit_nxt;
	logic [15:0] cnt1_ctrl_r, cnt1_ctrl_nxt, cnt2_ctrl_r, cnt2_ctrl_nxt;
	logic [15:0] brk_src_r, brk_src_nxt, brk_freq_r, brk_freq_nxt;
	logic [15:0] brk_time_r, brk_time_nxt;
	logic [31:0] cnt1_setp_r, cnt1_setp_nxt, cnt1_limit_r, cnt1_limit_nxt;
	logic [15:0] gear_num_r, gear_num_nxt, gear_den_r, gear_den_nxt;

	logic [31:0] raw1_r, raw1_nxt;
	logic [17:0] acc_r, acc_nxt;
	logic        gear_inc;
	logic [16:0] ms_div_r, ms_div_nxt;
	logic        ms_tick;
	logic [15:0] stall_r, stall_nxt;
	logic [31:0] last_r, last_nxt;
	logic        fault_r, fault_nxt;
	logic        reach1_r, reach2_r;
	logic [1:0]  stop_r, stop_nxt;

	logic [4:0]  pin_lvl, pin_rise;
	logic [31:0] cnt1_val;
	logic [15:0] cnt2_val;
	logic        hit1, hit2;
	logic [31:0] sel_cnt;
	logic        mon_act;
	logic        wr_go, rd_go, fault_clr;
	pcb_pkg::pcb_ctrl_t ctrl1, ctrl2;

	localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);

	// Byte-lane merge of a write into a 32-bit register
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Byte-lane merge of a write into a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [15:0] r;
		r[15:8] = s[1] ? d[15:8] : old[15:8];
		r[7:0]  = s[0] ? d[7:0] : old[7:0];
		return r;
	endfunction

	// ------------------------------------------------------------------
	// Pins and counters
	// ------------------------------------------------------------------
	pcb_sync #(.N(5)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin_in  ({pwr_down_in, cnt2_clr_in, cnt2_pulse_in, cnt1_clr_in, cnt1_pulse_in}),
		.level   (pin_lvl),
		.rise    (pin_rise)
	);

	assign ctrl1 = pcb_pkg::pcb_decode(cnt1_ctrl_r);
	assign ctrl2 = pcb_pkg::pcb_decode(cnt2_ctrl_r);

	pcb_count #(.W(32)) u_cnt1 (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.inc      (gear_inc),
		.clr      (pin_lvl[1]),
		.pwr_down (pin_rise[4]),
		.ctrl     (ctrl1),
		.limit    (cnt1_limit_r),
		.setp     (cnt1_setp_r),
		.count    (cnt1_val),
		.reached  (hit1)
	);

	pcb_count #(.W(16)) u_cnt2 (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.inc      (pin_rise[2]),
		.clr      (pin_lvl[3]),
		.pwr_down (pin_rise[4]),
		.ctrl     (ctrl2),
		.limit    (cnt2_limit_r),
		.setp     (cnt2_setp_r),
		.count    (cnt2_val),
		.reached  (hit2)
	);

	// ------------------------------------------------------------------
	// Gear, break detection and drive action
	// ------------------------------------------------------------------
	assign gear_inc = (acc_r >= {2'b00, gear_den_r});
	assign sel_cnt  = brk_src_r[0] ? {16'h0000, cnt2_val} : cnt1_val;
	assign mon_act  = (run_freq > brk_freq_r);
	assign ms_tick  = (ms_div_r == MS_LAST);

	always_comb begin
		raw1_nxt = raw1_r;
		acc_nxt  = acc_r;
		if (pin_lvl[1] || (pin_rise[4] && !ctrl1.retain)) begin
			raw1_nxt = '0;
			acc_nxt  = '0;
		end else begin
			if (pin_rise[0]) begin
				raw1_nxt = raw1_r + 32'h0000_0001;
			end
			acc_nxt = acc_r + (pin_rise[0] ? {2'b00, gear_num_r} : 18'h00000)
				- (gear_inc ? {2'b00, gear_den_r} : 18'h00000);
		end
		ms_div_nxt = (ms_tick || !mon_act) ? 17'h00000 : ms_div_r + 17'h00001;
		last_nxt   = sel_cnt;
		stall_nxt  = stall_r;
		if (!mon_act || (sel_cnt != last_r)) begin
			stall_nxt = 16'h0000;
		end else if (ms_tick && (stall_r < brk_time_r)) begin
			stall_nxt = stall_r + 16'h0001;
		end
		fault_nxt = fault_r & ~fault_clr;
		if (mon_act && (brk_time_r != 16'h0000) && (stall_r >= brk_time_r)) begin
			fault_nxt = 1'b1;
		end
		stop_nxt = 2'(PCB_RUN_CODE(hit1, ctrl1.stop_act, hit2, ctrl2.stop_act));
	end

	function automatic logic [1:0] PCB_RUN_CODE(input logic h1, input logic [1:0] a1,
		input logic h2, input logic [1:0] a2);
		logic [1:0] x1;
		logic [1:0] x2;
		x1 = h1 ? a1 : 2'h0;
		x2 = h2 ? a2 : 2'h0;
		return (x1 > x2) ? x1 : x2;
	endfunction

	// ------------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------------
	assign wr_go     = aw_have_r && w_have_r && !bvalid_r;
	assign rd_go     = s_axi_arvalid && arready_r;
	assign fault_clr = wr_go && (aw_addr_r == pcb_pkg::OFS_STATUS) && w_strb_r[0]
		&& w_data_r[pcb_pkg::STS_BRK_FAULT];

	always_comb begin
		aw_have_nxt = aw_have_r;
		aw_addr_nxt = aw_addr_r;
		w_have_nxt  = w_have_r;
		w_data_nxt  = w_data_r;
		w_strb_nxt  = w_strb_r;
		bvalid_nxt  = bvalid_r && !s_axi_bready;
		bresp_nxt   = bresp_r;
		cnt2_setp_nxt  = cnt2_setp_r;
		cnt2_limit_nxt = cnt2_limit_r;
		cnt1_ctrl_nxt  = cnt1_ctrl_r;
		cnt2_ctrl_nxt  = cnt2_ctrl_r;
		brk_src_nxt    = brk_src_r;
		brk_freq_nxt   = brk_freq_r;
		brk_time_nxt   = brk_time_r;
		cnt1_setp_nxt  = cnt1_setp_r;
		cnt1_limit_nxt = cnt1_limit_r;
		gear_num_nxt   = gear_num_r;
		gear_den_nxt   = gear_den_r;
		if (s_axi_awvalid && awready_r) begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r) begin
			w_have_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_strb_nxt = s_axi_wstrb;
		end
		if (wr_go) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = 2'h0;
			case ({aw_addr_r[7:2], 2'b00})
				pcb_pkg::OFS_CNT2_SETP:  cnt2_setp_nxt  = merge16(cnt2_setp_r, w_data_r, w_strb_r);
				pcb_pkg::OFS_CNT2_LIMIT: cnt2_limit_nxt = merge16(cnt2_limit_r, w_data_r, w_strb_r);
				pcb_pkg::OFS_CNT1_CTRL:  cnt1_ctrl_nxt  = merge16(cnt1_ctrl_r, w_data_r, w_strb_r);
				pcb_pkg::OFS_CNT2_CTRL:  cnt2_ctrl_nxt  = merge16(cnt2_ctrl_r, w_data_r, w_strb_r);
				pcb_pkg::OFS_BRK_SRC:    brk_src_nxt    = merge16(brk_src_r, w_data_r, w_strb_r);
				pcb_pkg::OFS_BRK_FREQ:   brk_freq_nxt   = merge16(brk_freq_r, w_data_r, w_strb_r);
				pcb_pkg::OFS_BRK_TIME:   brk_time_nxt   = merge16(brk_time_r, w_data_r, w_strb_r);
				pcb_pkg::OFS_CNT1_SETP:  cnt1_setp_nxt  = merge(cnt1_setp_r, w_data_r, w_strb_r);
				pcb_pkg::OFS_CNT1_LIMIT: cnt1_limit_nxt = merge(cnt1_limit_r, w_data_r, w_strb_r);
				pcb_pkg::OFS_GEAR_NUM:   gear_num_nxt   = merge16(gear_num_r, w_data_r, w_strb_r);
				pcb_pkg::OFS_GEAR_DEN:   gear_den_nxt   = merge16(gear_den_r, w_data_r, w_strb_r);
				pcb_pkg::OFS_CNT2_VALUE, pcb_pkg::OFS_CNT1_VALUE,
				pcb_pkg::OFS_CNT1_RAW, pcb_pkg::OFS_STATUS: bresp_nxt = 2'h0;
				default: bresp_nxt = 2'h2;
			endcase
		end
		awready_nxt = !aw_have_nxt && !bvalid_nxt;
		wready_nxt  = !w_have_nxt && !bvalid_nxt;
	end

	always_comb begin
		rvalid_nxt = rvalid_r && !s_axi_rready;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (rd_go) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = 2'h0;
			case ({s_axi_araddr[7:2], 2'b00})
				pcb_pkg::OFS_CNT2_VALUE: rdata_nxt = {16'h0000, cnt2_val};
				pcb_pkg::OFS_CNT2_SETP:  rdata_nxt = {16'h0000, cnt2_setp_r};
				pcb_pkg::OFS_CNT2_LIMIT: rdata_nxt = {16'h0000, cnt2_limit_r};
				pcb_pkg::OFS_CNT1_CTRL:  rdata_nxt = {16'h0000, cnt1_ctrl_r};
				pcb_pkg::OFS_CNT2_CTRL:  rdata_nxt = {16'h0000, cnt2_ctrl_r};
				pcb_pkg::OFS_BRK_SRC:    rdata_nxt = {16'h0000, brk_src_r};
				pcb_pkg::OFS_BRK_FREQ:   rdata_nxt = {16'h0000, brk_freq_r};
				pcb_pkg::OFS_BRK_TIME:   rdata_nxt = {16'h0000, brk_time_r};
				pcb_pkg::OFS_CNT1_VALUE: rdata_nxt = cnt1_val;
				pcb_pkg::OFS_CNT1_RAW:   rdata_nxt = raw1_r;
				pcb_pkg::OFS_CNT1_SETP:  rdata_nxt = cnt1_setp_r;
				pcb_pkg::OFS_CNT1_LIMIT: rdata_nxt = cnt1_limit_r;
				pcb_pkg::OFS_GEAR_NUM:   rdata_nxt = {16'h0000, gear_num_r};
				pcb_pkg::OFS_GEAR_DEN:   rdata_nxt = {16'h0000, gear_den_r};
				pcb_pkg::OFS_STATUS:     rdata_nxt = {29'h0, hit2, hit1, fault_r};
				default: begin
					rdata_nxt = 32'h0000_0000;
					rresp_nxt = 2'h2;
				end
			endcase
		end
		arready_nxt = !rvalid_nxt;
	end

	// ------------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= 2'h0;
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rresp_r   <= 2'h0;
			rdata_r   <= 32'h0000_0000;
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_have_r  <= 1'b0;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
			cnt2_setp_r  <= pcb_pkg::RST_CNT2_SETP;
			cnt2_limit_r <= pcb_pkg::RST_CNT2_LIMIT;
			cnt1_ctrl_r  <= pcb_pkg::RST_CNT1_CTRL;
			cnt2_ctrl_r  <= pcb_pkg::RST_CNT2_CTRL;
			brk_src_r    <= pcb_pkg::RST_BRK_SRC;
			brk_freq_r   <= pcb_pkg::RST_BRK_FREQ;
			brk_time_r   <= pcb_pkg::RST_BRK_TIME;
			cnt1_setp_r  <= pcb_pkg::RST_CNT1_SETP;
			cnt1_limit_r <= pcb_pkg::RST_CNT1_LIMIT;
			gear_num_r   <= pcb_pkg::RST_GEAR_NUM;
			gear_den_r   <= pcb_pkg::RST_GEAR_DEN;
			raw1_r   <= 32'h0000_0000;
			acc_r    <= 18'h00000;
			ms_div_r <= 17'h00000;
			stall_r  <= 16'h0000;
			last_r   <= 32'h0000_0000;
			fault_r  <= 1'b0;
			reach1_r <= 1'b0;
			reach2_r <= 1'b0;
			stop_r   <= 2'h0;
		end else begin
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			rresp_r   <= rresp_nxt;
			rdata_r   <= rdata_nxt;
			aw_have_r <= aw_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_have_r  <= w_have_nxt;
			w_data_r  <= w_data_nxt;
			w_strb_r  <= w_strb_nxt;
			cnt2_setp_r  <= (cnt2_setp_nxt == 16'h0000) ? cnt2_setp_r : cnt2_setp_nxt;
			cnt2_limit_r <= (cnt2_limit_nxt == 16'h0000) ? cnt2_limit_r : cnt2_limit_nxt;
			cnt1_ctrl_r  <= cnt1_ctrl_nxt;
			cnt2_ctrl_r  <= cnt2_ctrl_nxt;
			brk_src_r    <= brk_src_nxt;
			brk_freq_r   <= brk_freq_nxt;
			brk_time_r   <= brk_time_nxt;
			cnt1_setp_r  <= (cnt1_setp_nxt == 32'h0000_0000) ? cnt1_setp_r : cnt1_setp_nxt;
			cnt1_limit_r <= (cnt1_limit_nxt == 32'h0000_0000) ? cnt1_limit_r : cnt1_limit_nxt;
			gear_num_r   <= (gear_num_nxt == 16'h0000) ? gear_num_r : gear_num_nxt;
			gear_den_r   <= (gear_den_nxt == 16'h0000) ? gear_den_r : gear_den_nxt;
			raw1_r   <= raw1_nxt;
			acc_r    <= acc_nxt;
			ms_div_r <= ms_div_nxt;
			stall_r  <= stall_nxt;
			last_r   <= last_nxt;
			fault_r  <= fault_nxt;
			reach1_r <= hit1;
			reach2_r <= hit2;
			stop_r   <= stop_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign s_axi_awready    = awready_r;
	assign s_axi_wready     = wready_r;
	assign s_axi_bvalid     = bvalid_r;
	assign s_axi_bresp      = bresp_r;
	assign s_axi_arready    = arready_r;
	assign s_axi_rvalid     = rvalid_r;
	assign s_axi_rresp      = rresp_r;
	assign s_axi_rdata      = rdata_r;
	assign cnt1_reached_out = reach1_r;
	assign cnt2_reached_out = reach2_r;
	assign stop_cmd         = stop_r;
	assign brk_fault_out    = fault_r;

	localparam logic [1:0] PCB_RUN_UNUSED = 2'h0;
endmodule
`default_nettype wire

/* File: pcb_chk.sv */
// Checker on the pulse counter top ports
`timescale 1ns/1ps
`default_nettype none
module pcb_chk (
	input wire logic	aclk,
	input wire logic	aresetn,
	input wire logic	s_axi_awvalid,
	input wire logic	s_axi_awready,
	input wire logic	s_axi_wvalid,
	input wire logic	s_axi_wready,
	input wire logic	s_axi_bvalid,
	input wire logic	s_axi_bready,
	input wire logic [1:0]	s_axi_bresp,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic	s_axi_rvalid,
	input wire logic	s_axi_rready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic	cnt1_reached_out,
	input wire logic	cnt2_reached_out,
	input wire logic [1:0]	stop_cmd,
	input wire logic	brk_fault_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence none_reached;
		!cnt1_reached_out && !cnt2_reached_out;
	endsequence
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_wr_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	chk_stop_cause: assert property (none_reached [*2] |-> stop_cmd == 2'h0)
		else $error("stop without set value");
	chk_fault_keep: assert property (brk_fault_out && s_axi_awready && !s_axi_awvalid
		|=> brk_fault_out) else $error("fault lost");
	chk_reset_quiet: assert property (disable iff (1'b0) !aresetn
		|=> !s_axi_bvalid && !s_axi_rvalid && !brk_fault_out && stop_cmd == 2'h0)
		else $error("outputs active in reset");
endmodule
`default_nettype wire

/* File: pcb_src.sv */
// Pulse source model on one counter input pin
`timescale 1ns/1ps
`default_nettype none
module pcb_src (
	input wire logic	aclk,
	input wire logic	fire,
	input wire logic [3:0]	gap,
	output logic	pin,
	output logic	busy
);
	int t = 0;
	initial pin = 1'b0;
	assign busy = t != 0;
	// One pulse per request, high and low each gap+1 cycles
	always @(posedge aclk) begin
		if (fire && t == 0) t <= 2 * gap + 2;
		else if (t != 0) t <= t - 1;
		pin <= t > gap + 1;
	end
endmodule
`default_nettype wire

/* File: pcb_tb_top.sv */
// Testbench top for the pulse counter block
`timescale 1ns/1ps
`default_nettype none
module pcb_tb_top;
	logic	aclk = 1'h0, aresetn = 1'h0, fire = 1'h0, busy;
	logic [7:0]	s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]	s_axi_wdata = 32'h0, s_axi_rdata, rd_d, seed = 32'h2722915E;
	logic [3:0]	s_axi_wstrb = 4'hF, gap = 4'h0;
	logic [1:0]	s_axi_bresp, s_axi_rresp, stop_cmd, rs;
	logic	s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic	s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, cnt1_pulse_in = 1'h0;
	logic	cnt1_clr_in = 1'h0, cnt2_clr_in = 1'h0, pwr_down_in = 1'h0;
	logic	s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic	cnt2_pulse_in, cnt1_reached_out, cnt2_reached_out, brk_fault_out;
	logic [15:0]	run_freq = 16'h0;
	logic [31:0]	rv [8] = '{32'h0, 32'h3E8, 32'hFFFF, 32'h1, 32'h64, 32'h1, 32'h3E8, 32'h0};
	int	error_cnt = 0, cmp_count = 0, mc, lim, sp;

	pcb_top #(.MS_CYCLES(10)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.cnt1_pulse_in, .cnt1_clr_in, .cnt2_pulse_in, .cnt2_clr_in, .pwr_down_in,
		.run_freq, .cnt1_reached_out, .cnt2_reached_out, .stop_cmd, .brk_fault_out);
	pcb_src src (.aclk, .fire, .gap, .pin(cnt2_pulse_in), .busy);

	always #4 aclk = ~aclk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		rd_d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task pulse(input int n);
		repeat (n) begin
			@(posedge aclk);
			fire <= 1'h1;
			gap <= 4'(rnd() % 4);
			@(posedge aclk);
			fire <= 1'h0;
			do @(posedge aclk); while (busy);
		end
		repeat (6) @(posedge aclk);
	endtask

	task final_report();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#400000;
		error_cnt++;
		final_report();
	end

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			rd(8'(4 * i));
			chk("reset value", rv[i], rd_d);
		end
		rd(8'h3C);
		chk("unmapped", 32'h2, {30'h0, rs});
		wr(8'h3C, 32'h0);
		chk("unmapped write", 32'h2, {30'h0, rs});
		for (int t = 0; t < 4; t++) begin
			sp = 2 + int'(rnd() % 4);
			lim = sp + 1 + int'(rnd() % 3);
			wr(8'h04, 32'(sp));
			wr(8'h08, 32'(lim));
			wr(8'h10, 32'(10 * t + t % 2));
			cnt2_clr_in <= 1'h1;
			repeat (6) @(posedge aclk);
			cnt2_clr_in <= 1'h0;
			mc = 0;
			for (int k = 0; k <= lim; k++) begin
				pulse(1);
				mc = (mc < lim) ? mc + 1 : (t % 2 ? 0 : lim);
				rd(8'h00);
				chk("count", 32'(mc), rd_d);
				chk("reached", 32'(mc >= sp), 32'(cnt2_reached_out));
				chk("stop", 32'(mc >= sp ? t : 0), 32'(stop_cmd));
			end
		end
		for (int h = 0; h < 2; h++) begin
			wr(8'h10, 32'(100 * h));
			pulse(2);
			pwr_down_in <= 1'h1;
			repeat (6) @(posedge aclk);
			pwr_down_in <= 1'h0;
			rd(8'h00);
			chk("power down", 32'(2 * h), rd_d);
		end
		wr(8'h30, 32'h3);
		wr(8'h28, 32'h5);
		repeat (2) begin
			cnt1_pulse_in <= 1'h1;
			repeat (4) @(posedge aclk);
			cnt1_pulse_in <= 1'h0;
			repeat (8) @(posedge aclk);
		end
		rd(8'h24);
		chk("raw count", 32'h2, rd_d);
		rd(8'h20);
		chk("geared count", 32'h6, rd_d);
		chk("reached 1", 32'h1, 32'(cnt1_reached_out));
		cnt1_clr_in <= 1'h1;
		repeat (6) @(posedge aclk);
		cnt1_clr_in <= 1'h0;
		rd(8'h20);
		chk("clear 1", 32'h0, rd_d);
		wr(8'h1C, 32'h2);
		run_freq <= 16'h03E9;
		repeat (60) @(posedge aclk);
		chk("fault", 32'h1, 32'(brk_fault_out));
		run_freq <= 16'h03E8;
		wr(8'h38, 32'h1);
		repeat (60) @(posedge aclk);
		chk("idle", 32'h0, 32'(brk_fault_out));
		wr(8'h10, 32'h1);
		wr(8'h1C, 32'h3);
		for (int s = 0; s < 2; s++) begin
			wr(8'h14, 32'(s));
			run_freq <= 16'h03E9;
			pulse(8);
			chk("source", 32'(s == 0), 32'(brk_fault_out));
			run_freq <= 16'h0;
			wr(8'h38, 32'h1);
		end
		final_report();
	end
endmodule

bind pcb_top pcb_chk chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cnt1_reached_out,
	.cnt2_reached_out, .stop_cmd, .brk_fault_out);
`default_nettype wire
